/* File: design/lspim_pkg.sv */
// constants and types of the byte-port spi master
package lspim_pkg;
   localparam logic [11:0] OFS_EVENT    = 12'h108;
   localparam logic [11:0] OFS_IRQ_SET  = 12'h304;
   localparam logic [11:0] OFS_IRQ_CLR  = 12'h308;
   localparam logic [11:0] OFS_ENABLE   = 12'h500;
   localparam logic [11:0] OFS_SCK_PSEL = 12'h508;
   localparam logic [11:0] OFS_OUT_PSEL = 12'h50C;
   localparam logic [11:0] OFS_IN_PSEL  = 12'h510;
   localparam logic [11:0] OFS_RXD      = 12'h518;
   localparam logic [11:0] OFS_TXD      = 12'h51C;
   localparam logic [11:0] OFS_RATE     = 12'h524;
   localparam logic [11:0] OFS_FORMAT   = 12'h554;
   localparam int          ADDR_W       = 12;
   localparam logic [31:0] PSEL_RESET   = 32'hFFFFFFFF;
   localparam logic [31:0] RATE_RESET   = 32'h04000000;
   localparam logic [31:0] RATE_K125    = 32'h02000000;
   localparam logic [31:0] RATE_M8      = 32'h80000000;
   localparam int          PSEL_CONN_BIT = 31;
   localparam int          PIN_W         = 6;
   localparam int          FMT_ORDER_BIT = 0;
   localparam int          FMT_PHASE_BIT = 1;
   localparam int          FMT_POL_BIT   = 2;
   localparam int          BITS_PER_UNIT = 8;
   // half serial period in system clocks at the slowest rate, 25 MHz / 125 kHz / 2
   localparam int          SYS_CLK_HZ    = 25000000;
   localparam int          SLOW_RATE_HZ  = 125000;
   localparam logic [7:0]  HALF_SLOW     = 8'(SYS_CLK_HZ / SLOW_RATE_HZ / 2);
   localparam logic [7:0]  HALF_MIN      = 8'h01;
   localparam logic [1:0]  RX_MOVE_DLY   = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL, ST_SETTLE} lspim_state_t;
endpackage : lspim_pkg

/* File: design/lspim_core.sv */
// byte-port spi master: register slave, serial engine, tx/rx double buffers
// What this block does
// - transmit and receive paths are each two bytes deep.
// - all four clock modes from polarity and phase bits.
// - disconnected clock or data-out route drops that output's enable; the data-in route's connect bit is unused.
// - routes act only while enabled; software changes them while disabled.
// - writing the transmit register starts a transfer.
// - second byte accepted at once, sent in write order.
// - one byte received for every byte sent.
// - second byte can land in holding while first is still unread.
// - byte-done event set whenever a byte enters visible receive register.
// - reading receive register moves held byte in at once.
// - second byte's event waits until it advances to visible register.
// - clocking stops when no byte remains to send.
// - received byte moves in shortly after the last bit period.
// - event register reads 0 until set, then 1.
// - order bit 0 sends msb first, 1 lsb first.
// - phase 0 samples leading edge; phase 1 samples trailing edge.
// - rate codes 125 kbps to 8 Mbps, doubling per step below the two fastest codes, which share one-cycle halves.
`timescale 1ns/1ns
module lspim_core
   import lspim_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   input  wire logic [lspim_pkg::ADDR_W-1:0] addr,
   input  wire logic [31:0]                wdata,
   input  wire logic                       wr_stb,
   input  wire logic                       rd_stb,
   output logic      [31:0]                rdata,
   output logic                            irq,
   output logic                            sck_out,
   output logic                            sck_oe,
   output logic                            mosi_out,
   output logic                            mosi_oe,
   input  wire logic                       miso_in,
   output logic      [lspim_pkg::PIN_W-1:0] sck_pin,
   output logic      [lspim_pkg::PIN_W-1:0] mosi_pin,
   output logic      [lspim_pkg::PIN_W-1:0] miso_pin
);
   import lspim_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic        event_reg;
   logic        irq_en_reg;
   logic        enable_reg;
   logic [31:0] sck_psel_reg;
   logic [31:0] out_psel_reg;
   logic [31:0] in_psel_reg;
   logic [31:0] rate_reg;
   logic [2:0]  format_reg;
   logic [31:0] rdata_reg;
   logic [7:0]  txd_reg;
   logic        txd_full_reg;
   logic [7:0]  txh_reg;
   logic        txh_full_reg;
   logic [7:0]  rxd_reg;
   logic [7:0]  rxh_reg;
   logic        rxh_full_reg;
   logic        rxd_full_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  rx_shift_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  div_cnt_reg;
   logic [1:0]  settle_cnt_reg;
   logic        sck_reg;
   logic        mosi_reg;
   logic        miso_meta_reg;
   logic        miso_sync_reg;
   lspim_state_t state_reg;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire wr_event  = wr_stb && (addr == OFS_EVENT);
   wire wr_irqset = wr_stb && (addr == OFS_IRQ_SET);
   wire wr_irqclr = wr_stb && (addr == OFS_IRQ_CLR);
   wire wr_enable = wr_stb && (addr == OFS_ENABLE);
   wire cfg_ok    = wr_stb && !enable_reg; // routes frozen while running
   wire wr_sckp   = cfg_ok && (addr == OFS_SCK_PSEL);
   wire wr_outp   = cfg_ok && (addr == OFS_OUT_PSEL);
   wire wr_inp    = cfg_ok && (addr == OFS_IN_PSEL);
   wire wr_txd    = wr_stb && (addr == OFS_TXD);
   wire wr_rate   = wr_stb && (addr == OFS_RATE);
   wire wr_format = wr_stb && (addr == OFS_FORMAT);
   wire rd_rxd    = rd_stb && (addr == OFS_RXD);

   wire cpol      = format_reg[FMT_POL_BIT];
   wire cpha      = format_reg[FMT_PHASE_BIT];
   wire lsb_first = format_reg[FMT_ORDER_BIT];

   // ----------------------------------------------------------------
   // bit rate: half period in system clocks, clamped to one cycle
   // ----------------------------------------------------------------
   // 8 Mbps cannot be met at 25 MHz; fastest codes share one-cycle halves
   logic [7:0] half_cnt;
   always_comb
   begin
      case (rate_reg)
         32'h02000000: half_cnt = HALF_SLOW;
         32'h04000000: half_cnt = HALF_SLOW >> 1;
         32'h08000000: half_cnt = HALF_SLOW >> 2;
         32'h10000000: half_cnt = HALF_SLOW >> 3;
         32'h20000000: half_cnt = HALF_SLOW >> 4;
         32'h40000000: half_cnt = HALF_MIN;
         RATE_M8:      half_cnt = HALF_MIN;
         default:      half_cnt = HALF_SLOW >> 1;
      endcase
   end
   wire tick = (div_cnt_reg == 8'h00);

   // ----------------------------------------------------------------
   // engine
   // ----------------------------------------------------------------
   wire       work_avail = txd_full_reg;
   wire       last_bit   = (bit_cnt_reg == 4'(BITS_PER_UNIT - 1));
   wire [7:0] rx_next    = lsb_first ? {miso_sync_reg, rx_shift_reg[7:1]}
                                     : {rx_shift_reg[6:0], miso_sync_reg};
   wire       out_bit    = lsb_first ? shift_reg[0] : shift_reg[7];
   wire [7:0] sh_next    = lsb_first ? {1'b0, shift_reg[7:1]} : {shift_reg[6:0], 1'b0};
   wire       start      = enable_reg && (state_reg == ST_IDLE) && work_avail;
   wire       done_byte  = (state_reg == ST_SETTLE) && (settle_cnt_reg == 2'h0) && tick;
   // receive landing: into visible if empty-able, else into holding
   // visible stage stays busy until software reads it, not until the event is cleared
   wire       vis_busy   = rxh_full_reg || (rxd_full_reg && !rd_rxd);
   wire       rx_to_vis  = done_byte && !vis_busy;
   wire       hold_move  = rd_rxd && rxh_full_reg;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_reg      <= ST_IDLE;
         div_cnt_reg    <= 8'h00;
         bit_cnt_reg    <= 4'h0;
         settle_cnt_reg <= 2'h0;
         sck_reg        <= 1'b0;
         mosi_reg       <= 1'b0;
         shift_reg      <= 8'h00;
         rx_shift_reg   <= 8'h00;
      end
      else
      begin
         div_cnt_reg <= tick ? half_cnt - 8'h01 : div_cnt_reg - 8'h01;
         case (state_reg)
            ST_IDLE:
            begin
               sck_reg     <= cpol; // idle at polarity
               bit_cnt_reg <= 4'h0;
               if (start)
               begin
                  shift_reg   <= txd_reg; // oldest byte first
                  mosi_reg    <= lsb_first ? txd_reg[0] : txd_reg[7];
                  div_cnt_reg <= half_cnt - 8'h01;
                  state_reg   <= ST_LEAD;
               end
               else
                  mosi_reg <= 1'b0;
            end
            ST_LEAD:
               if (tick)
               begin
                  sck_reg   <= ~cpol;
                  state_reg <= ST_TRAIL;
                  if (!cpha)
                     rx_shift_reg <= rx_next; // sample leading
                  else
                  begin
                     mosi_reg  <= out_bit; // shift leading
                     shift_reg <= sh_next;
                  end
               end
            ST_TRAIL:
               if (tick)
               begin
                  sck_reg <= cpol;
                  if (cpha)
                     rx_shift_reg <= rx_next;
                  else
                  begin
                     shift_reg <= sh_next;
                     mosi_reg  <= lsb_first ? sh_next[0] : sh_next[7];
                  end
                  if (last_bit) // eight periods per unit
                  begin
                     settle_cnt_reg <= RX_MOVE_DLY;
                     state_reg      <= ST_SETTLE;
                  end
                  else
                  begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     state_reg   <= ST_LEAD;
                  end
               end
            ST_SETTLE: // short delay after last period
               if (tick)
               begin
                  if (settle_cnt_reg == 2'h0)
                     state_reg <= ST_IDLE; // stop if nothing left
                  else
                     settle_cnt_reg <= settle_cnt_reg - 2'h1;
               end
            default: state_reg <= ST_IDLE;
         endcase
         if (!enable_reg)
            state_reg <= ST_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // tx double buffer
   // ----------------------------------------------------------------
   wire tx_pop = start;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         txd_reg      <= 8'h00;
         txd_full_reg <= 1'b0;
         txh_reg      <= 8'h00;
         txh_full_reg <= 1'b0;
      end
      else
      begin
         // a third write while both stages full is dropped unless tx_pop frees a stage in that cycle
         if (tx_pop)
         begin
            txd_full_reg <= txh_full_reg || wr_txd;
            txd_reg      <= txh_full_reg ? txh_reg : wdata[7:0];
            txh_full_reg <= txh_full_reg && wr_txd;
            if (txh_full_reg && wr_txd)
               txh_reg <= wdata[7:0];
         end
         else if (wr_txd && !txd_full_reg)
         begin
            txd_reg      <= wdata[7:0];
            txd_full_reg <= 1'b1;
         end
         else if (wr_txd && !txh_full_reg)
         begin
            txh_reg      <= wdata[7:0];
            txh_full_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // rx double buffer and byte-done event
   // ----------------------------------------------------------------
   // a byte arriving with both stages full overwrites holding
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rxd_reg      <= 8'h00;
         rxh_reg      <= 8'h00;
         rxh_full_reg <= 1'b0;
         rxd_full_reg <= 1'b0;
         event_reg    <= 1'b0;
      end
      else
      begin
         if (hold_move)
         begin
            rxd_reg      <= rxh_reg;
            rxh_full_reg <= done_byte;
            if (done_byte)
               rxh_reg <= rx_shift_reg;
         end
         else if (rx_to_vis)
            rxd_reg <= rx_shift_reg;
         else if (done_byte)
         begin
            rxh_reg      <= rx_shift_reg; // held, event withheld
            rxh_full_reg <= 1'b1;
         end
         if (hold_move || rx_to_vis)
            rxd_full_reg <= 1'b1; // unread byte now visible
         else if (rd_rxd)
            rxd_full_reg <= 1'b0;
         // set beats software clear
         if (hold_move || rx_to_vis)
            event_reg <= 1'b1;
         else if (wr_event && !wdata[0])
            event_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         irq_en_reg   <= 1'b0;
         enable_reg   <= 1'b0;
         sck_psel_reg <= PSEL_RESET;
         out_psel_reg <= PSEL_RESET;
         in_psel_reg  <= PSEL_RESET;
         rate_reg     <= RATE_RESET;
         format_reg   <= 3'h0;
      end
      else
      begin
         if (wr_irqset && wdata[0])
            irq_en_reg <= 1'b1;
         else if (wr_irqclr && wdata[0])
            irq_en_reg <= 1'b0;
         if (wr_enable)
            enable_reg <= wdata[0];
         if (wr_sckp)
            sck_psel_reg <= wdata;
         if (wr_outp)
            out_psel_reg <= wdata;
         if (wr_inp)
            in_psel_reg <= wdata;
         if (wr_rate)
            rate_reg <= wdata;
         if (wr_format)
            format_reg <= wdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb
   begin
      case (addr)
         OFS_EVENT:    rd_mux = {31'h0, event_reg};
         OFS_IRQ_SET:  rd_mux = {31'h0, irq_en_reg};
         OFS_IRQ_CLR:  rd_mux = {31'h0, irq_en_reg};
         OFS_ENABLE:   rd_mux = {31'h0, enable_reg};
         OFS_SCK_PSEL: rd_mux = sck_psel_reg;
         OFS_OUT_PSEL: rd_mux = out_psel_reg;
         OFS_IN_PSEL:  rd_mux = in_psel_reg;
         OFS_RXD:      rd_mux = {24'h0, rxd_reg};
         OFS_TXD:      rd_mux = {24'h0, txd_reg};
         OFS_RATE:     rd_mux = rate_reg;
         OFS_FORMAT:   rd_mux = {29'h0, format_reg};
         default:      rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdata_reg     <= 32'h00000000;
         miso_meta_reg <= 1'b0;
         miso_sync_reg <= 1'b0;
      end
      else
      begin
         rdata_reg     <= rd_stb ? rd_mux : 32'h00000000;
         miso_meta_reg <= miso_in;
         miso_sync_reg <= miso_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // pin routing
   // ----------------------------------------------------------------
   wire sck_conn  = enable_reg && !sck_psel_reg[PSEL_CONN_BIT];
   wire mosi_conn = enable_reg && !out_psel_reg[PSEL_CONN_BIT];
   assign rdata    = rdata_reg;
   assign irq      = irq_en_reg && event_reg;
   assign sck_out  = sck_reg;
   assign sck_oe   = sck_conn;
   assign mosi_out = mosi_reg;
   assign mosi_oe  = mosi_conn;
   assign sck_pin  = sck_psel_reg[PIN_W-1:0];
   assign mosi_pin = out_psel_reg[PIN_W-1:0];
   assign miso_pin = in_psel_reg[PIN_W-1:0];
endmodule : lspim_core

/* File: tb/lspim_chk_sva.sv */
// assertion checker of the byte-port spi master
`timescale 1ns/1ns
module lspim_chk
   import lspim_pkg::*;
(
   input wire logic                        sys_clk,
   input wire logic                        reset,
   input wire logic [lspim_pkg::ADDR_W-1:0] addr,
   input wire logic [31:0]                 wdata,
   input wire logic                        wr_stb,
   input wire logic                        rd_stb,
   input wire logic [31:0]                 rdata,
   input wire logic                        sck_out,
   input wire logic                        sck_oe,
   input wire logic                        mosi_out,
   input wire logic                        mosi_oe,
   input wire logic [lspim_pkg::PIN_W-1:0] sck_pin
);
   // --------------------------------------------------
   // shadow of config writes, idle detection
   // --------------------------------------------------
   localparam int QN = 600;
   logic       en_q, pol_q, sck_q;
   logic [6:0] sck_rt, out_rt;
   logic [9:0] quiet;
   logic [3:0] tog;
   wire        wr_cfg = wr_stb && !en_q;
   wire        moved  = sck_out != sck_q;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         en_q   <= 1'b0;
         pol_q  <= 1'b0;
         sck_rt <= 7'h7F;
         out_rt <= 7'h7F;
      end
      else
      begin
         if (wr_stb && addr == OFS_ENABLE) en_q <= wdata[0];
         if (wr_stb && addr == OFS_FORMAT) pol_q <= wdata[FMT_POL_BIT];
         if (wr_cfg && addr == OFS_SCK_PSEL) sck_rt <= {wdata[31], wdata[5:0]};
         if (wr_cfg && addr == OFS_OUT_PSEL) out_rt <= {wdata[31], wdata[5:0]};
      end
   end
   // idle threshold well above the gap between bytes at the slowest rate
   always_ff @(posedge sys_clk)
   begin
      sck_q <= reset ? 1'b0 : sck_out;
      quiet <= (reset || moved) ? 10'h000 : quiet + {9'h000, quiet != 10'h3FF};
      // leading edges only: a polarity change while idle is a single move
      tog   <= reset ? 4'h0 : tog + {3'h0, moved && (sck_out != pol_q)};
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_txd_wr;
      wr_stb && addr == OFS_TXD && en_q && quiet > 10'd600;
   endsequence
   sequence s_first_edge;
      ##[1:210] moved;
   endsequence
   property p_start;
      s_txd_wr |-> s_first_edge;
   endproperty
   property p_sck_oe;
      sck_oe == (en_q && !sck_rt[6]);
   endproperty
   property p_mosi_oe;
      mosi_oe == (en_q && !out_rt[6]);
   endproperty
   property p_pin;
      sck_pin == sck_rt[5:0];
   endproperty
   property p_len;
      quiet == QN |-> tog[2:0] == 3'h0;
   endproperty
   property p_idle_pol;
      quiet == QN |-> sck_out == pol_q;
   endproperty
   property p_mosi_idle;
      quiet == QN |-> !mosi_out;
   endproperty
   property p_evt_rd;
      rd_stb && addr == OFS_EVENT |=> rdata[31:1] == 31'h0;
   endproperty
   a_start: assert property (p_start) else $error("no clock after transmit write");
   a_sck_oe: assert property (p_sck_oe) else $error("clock enable wrong");
   a_mosi_oe: assert property (p_mosi_oe) else $error("data enable wrong");
   a_pin: assert property (p_pin) else $error("clock pin wrong");
   a_len: assert property (p_len) else $error("clock periods not a multiple of eight");
   a_idle_pol: assert property (p_idle_pol) else $error("clock idle level wrong");
   a_mosi_idle: assert property (p_mosi_idle) else $error("data idle level wrong");
   a_evt_rd: assert property (p_evt_rd) else $error("event upper bits set");
endmodule : lspim_chk
bind lspim_core lspim_chk i_chk (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rdata(rdata), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
   .sck_pin(sck_pin));

/* File: tb/lspim_slave.sv */
// spi slave model facing the byte-port master
`timescale 1ns/1ns
module lspim_slave
(
   input  wire logic        sck,
   input  wire logic        mosi,
   input  wire logic        cs_n,
   input  wire logic        cpol,
   input  wire logic        cpha,
   input  wire logic        lsb,
   input  wire logic [23:0] tx_pat,
   output logic             miso,
   output logic [23:0]      rx_log,
   output int               bits
);
   int         lead_n  = 0;
   int         trail_n = 0;
   int         idx;
   logic [7:0] cur;
   logic [7:0] sr      = 8'h00;
   logic       off_val = 1'b0;
   initial bits = 0;
   initial rx_log = 24'h000000;
   always_comb
   begin
      idx = cpha ? lead_n - 1 : trail_n;
      if (idx < 0) idx = 0;
      cur = tx_pat[23 - 8 * ((idx / 8) % 3) -: 8];
      miso = cs_n ? off_val : (lsb ? cur[idx % 8] : cur[7 - idx % 8]);
   end
   // chip select comes from a gpio of the bench
   always @(negedge cs_n)
   begin
      lead_n = 0;
      trail_n = 0;
      bits = 0;
   end
   // released line shows the inverse, never the last bit
   always @(posedge cs_n) off_val = ~miso;
   always @(sck)
   begin
      if (!cs_n)
      begin
         if (sck != cpol) lead_n++;
         else trail_n++;
         if ((sck != cpol) != cpha)
         begin
            sr = lsb ? {mosi, sr[7:1]} : {sr[6:0], mosi};
            bits++;
            if (bits % 8 == 0) rx_log = {rx_log[15:0], sr};
         end
      end
   end
endmodule : lspim_slave

/* File: tb/lspim_core_tb_top.sv */
// self-checking bench of the byte-port spi master
`timescale 1ns/1ns
module lspim_core_tb_top;
   import lspim_pkg::*;
   logic              sys_clk = 1'b0;
   logic              reset   = 1'b1;
   logic [ADDR_W-1:0] addr    = '0;
   logic [31:0]       wdata   = '0;
   logic              wr_stb  = 1'b0;
   logic              rd_stb  = 1'b0;
   logic [31:0]       rdata, d;
   logic              irq, sck_out, sck_oe, mosi_out, mosi_oe, miso, sck_q = 1'b0;
   logic [PIN_W-1:0]  sck_pin, mosi_pin, miso_pin;
   logic              cs_n = 1'b1, cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
   logic [23:0]       tx_pat = '0, rx_log, txw;
   int                bits, fails = 0, cmp_count = 0, hcnt = 0, half_seen = 0, tog_n = 0, t0;
   logic [31:0]       rates [4] = '{32'h08000000, RATE_RESET, RATE_K125, 32'h08000000};
   int                halves [4] = '{25, 50, 100, 25};
   lspim_core i_dut (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
      .mosi_oe(mosi_oe), .miso_in(miso), .sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso_pin(miso_pin));
   lspim_slave i_slave (.sck(sck_out), .mosi(mosi_out), .cs_n(cs_n), .cpol(cpol), .cpha(cpha), .lsb(lsb),
      .tx_pat(tx_pat), .miso(miso), .rx_log(rx_log), .bits(bits));
   initial forever #20 sys_clk = ~sys_clk;
   // --------------------------------------------------
   // serial clock half period and edge count
   // --------------------------------------------------
   always @(posedge sys_clk)
   begin
      sck_q <= sck_out;
      hcnt <= (sck_out !== sck_q) ? 1 : hcnt + 1;
      if (sck_out !== sck_q) half_seen <= hcnt;
      if (sck_out !== sck_q) tog_n <= tog_n + 1;
   end
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // write leaves the strobe up so writes may follow back to back
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      rd_stb <= 1'b0;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a);
      addr <= a;
      wr_stb <= 1'b0;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
      @(posedge sys_clk);
   endtask : rd
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string name);
      rd(a);
      chk(name, d, exp);
   endtask : rdc
   task automatic idle(input int n);
      wr_stb <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask : idle
   task automatic wait_evt();
      d = '0;
      for (int i = 0; i < 4000 && d[0] !== 1'b1; i++) rd(OFS_EVENT);
      if (d[0] !== 1'b1)
      begin
         fails++;
         final_report();
      end
   endtask : wait_evt
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      final_report();
   end
   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      chk("sck_oe", sck_oe, 0);
      rdc(OFS_RATE, RATE_RESET, "rate");
      rdc(OFS_SCK_PSEL, PSEL_RESET, "sck route");
      rdc(OFS_EVENT, 0, "event");
      rdc(12'h0FC, 0, "unmapped");
      wr(OFS_SCK_PSEL, 32'h5);
      wr(OFS_OUT_PSEL, 32'h6);
      wr(OFS_IN_PSEL, 32'h7);
      wr(OFS_ENABLE, 32'h1);
      idle(1);
      chk("oe", {sck_oe, mosi_oe}, 2'b11);
      chk("pins", {sck_pin, mosi_pin, miso_pin}, {6'h05, 6'h06, 6'h07});
      wr(OFS_SCK_PSEL, 32'hA);
      rdc(OFS_SCK_PSEL, 32'h5, "locked route");
      for (int m = 0; m < 4; m++)
      begin
         {cpol, cpha} = 2'(m);
         lsb = cpol ^ cpha;
         txw = 24'h3CA581 ^ {3{8'(m)}};
         tx_pat = 24'h5AC30F ^ {3{8'(m * 16)}};
         wr(OFS_FORMAT, {29'h0, cpol, cpha, lsb});
         wr(OFS_RATE, rates[m]);
         idle(2);
         chk("idle clock", sck_out, cpol);
         t0 = tog_n;
         cs_n = 1'b0;
         wr(OFS_TXD, txw[23:16]);
         wr(OFS_TXD, txw[15:8]);
         wait_evt();
         wr(OFS_EVENT, 0);
         wr(OFS_TXD, txw[7:0]);
         idle(1);
         for (int i = 0; i < 3000 && bits < 16; i++) @(posedge sys_clk);
         idle(4 * halves[m] + 8);
         rdc(OFS_EVENT, 0, "held event");
         rdc(OFS_RXD, tx_pat[23:16], "rx 0");
         rdc(OFS_EVENT, 1, "moved event");
         wr(OFS_EVENT, 0);
         rdc(OFS_RXD, tx_pat[15:8], "rx 1");
         wait_evt();
         rdc(OFS_RXD, tx_pat[7:0], "rx 2");
         wr(OFS_EVENT, 0);
         idle(650);
         chk("slave rx", rx_log, txw);
         chk("half period", half_seen, halves[m]);
         chk("sck edges", tog_n - t0, 48);
         cs_n = 1'b1;
      end
      wr(OFS_RATE, RATE_M8);
      wr(OFS_IRQ_SET, 1);
      wr(OFS_TXD, 32'h55);
      wait_evt();
      chk("irq", irq, 1);
      chk("fast half", half_seen, 1);
      wr(OFS_IRQ_CLR, 1);
      idle(1);
      chk("irq off", irq, 0);
      wr(OFS_EVENT, 0);
      wr(OFS_ENABLE, 0);
      wr(OFS_OUT_PSEL, 32'h80000006);
      wr(OFS_ENABLE, 1);
      idle(1);
      chk("data off", {sck_oe, mosi_oe}, 2'b10);
      final_report();
   end
endmodule : lspim_core_tb_top
